// ---- inc/aof_consts.svh ----
// Offsets, field positions, reset values and cutoff table codes of the acceleration output filter configuration.
`ifndef AOF_CONSTS_SVH
`define AOF_CONSTS_SVH

`define AOF_ADDR_IDENTITY   8'h0D
`define AOF_ADDR_RANGE_CFG  8'h0E
`define AOF_ADDR_CUTOFF_CFG 8'h0F

`define AOF_BIT_FILT_OUT    4
`define AOF_BIT_PULSE_BYP   5
`define AOF_BIT_PULSE_LPF   4
`define AOF_RANGE_MASK      8'h13
`define AOF_CUTOFF_MASK     8'h33

`define AOF_RST_RANGE_CFG   8'h00
`define AOF_RST_CUTOFF_CFG  8'h00

// Cutoff is reported as a halving count: 0 is 16 Hz, each step halves it.
`define AOF_SHIFT_NORM_SLOW 4'h3
`define AOF_SHIFT_LPLN_SLOW 4'h5
`define AOF_SHIFT_LP_SLOW   4'h6
`define AOF_ODR_SLOW_FIRST  3'h5

`endif

// ---- inc/aof_pkg.sv ----
// Types shared by the acceleration output filter configuration modules.
package aof_pkg;

  typedef enum logic [1:0]
  {
    AOF_OS_NORMAL = 2'h0,
    AOF_OS_LPLN   = 2'h1,
    AOF_OS_HIRES  = 2'h2,
    AOF_OS_LP     = 2'h3
  } aof_osmode_e;

  // Rate codes 0..7 stand for 800, 400, 200, 100, 50, 12.5, 6.25 and 1.56 Hz.
  typedef logic [2:0] aof_odr_t;

  typedef struct packed
  {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } aof_axes_s;

endpackage

// ---- src/aof_cutoff_lut.sv ----
// Cutoff table: halving count for the current rate, oversampling mode and select code.
`include "aof_consts.svh"
module aof_cutoff_lut
  import aof_pkg::*;
(
  // Operating point
  input  wire aof_osmode_e mode_in,
  input  wire aof_odr_t    odr_in,
  input  wire logic [1:0]  sel_in,
  // Result
  output logic [3:0]       shift_out
);

  logic [3:0] base;
  logic       slow;

  always_comb
  begin
    slow = (odr_in >= `AOF_ODR_SLOW_FIRST);
    case (mode_in)
      AOF_OS_NORMAL:
        base = slow ? `AOF_SHIFT_NORM_SLOW : ((odr_in <= 3'h1) ? 4'h0 : {1'b0, odr_in} - 4'h1);
      AOF_OS_LPLN:
        base = slow ? `AOF_SHIFT_LPLN_SLOW : ((odr_in <= 3'h1) ? 4'h0 : {1'b0, odr_in} - 4'h1);
      AOF_OS_HIRES:
        base = 4'h0;
      default:
        base = slow ? `AOF_SHIFT_LP_SLOW : {1'b0, odr_in};
    endcase
    shift_out = base + {2'b00, sel_in};
  end

endmodule

// ---- src/aof_top.sv ----
// Register file and output routing of the acceleration output filter configuration.
`include "aof_consts.svh"
module aof_top
  import aof_pkg::*;
#(
  // Arbitrary neutral identity value; a custom part may use another.
  parameter logic [7:0] ID_VALUE = 8'h5A
)
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // Register port from the serial bus engine
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  output logic             reg_rvalid_out,
  // Operating point from the sensor core
  input  wire aof_odr_t    odr_in,
  input  wire aof_osmode_e osmode_in,
  // Sample streams
  input  wire logic        sample_valid_in,
  input  wire aof_axes_s   raw_sample_in,
  input  wire aof_axes_s   hp_sample_in,
  output aof_axes_s        out_sample_out,
  output logic             out_valid_out,
  output aof_axes_s        pulse_sample_out,
  // Configuration towards the core
  output logic [1:0]       full_scale_range_out,
  output logic [3:0]       cutoff_shift_out,
  output logic             filtered_output_select_out,
  output logic             pulse_highpass_bypass_out,
  output logic             pulse_lowpass_enable_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0] range_cfg_ff;
  logic [7:0] cutoff_cfg_ff;
  logic [3:0] nxt_cutoff_shift;

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      range_cfg_ff  <= `AOF_RST_RANGE_CFG;
      cutoff_cfg_ff <= `AOF_RST_CUTOFF_CFG;
    end
    else if (reg_wr_in)
    begin
      // The identity address has no storage, so a write there lands nowhere.
      if (reg_addr_in == `AOF_ADDR_RANGE_CFG)
        range_cfg_ff <= reg_wdata_in & `AOF_RANGE_MASK;
      else if (reg_addr_in == `AOF_ADDR_CUTOFF_CFG)
        cutoff_cfg_ff <= reg_wdata_in & `AOF_CUTOFF_MASK;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      if (!reg_rd_in)
        reg_rdata_out <= 8'h00;
      else if (reg_addr_in == `AOF_ADDR_IDENTITY)
        reg_rdata_out <= ID_VALUE;
      else if (reg_addr_in == `AOF_ADDR_RANGE_CFG)
        reg_rdata_out <= range_cfg_ff;
      else if (reg_addr_in == `AOF_ADDR_CUTOFF_CFG)
        reg_rdata_out <= cutoff_cfg_ff;
      else
        reg_rdata_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration outputs. Registered so the core sees one clean update per write.

  aof_cutoff_lut u_lut
  (
    .mode_in   (osmode_in),
    .odr_in    (odr_in),
    .sel_in    (cutoff_cfg_ff[1:0]),
    .shift_out (nxt_cutoff_shift)
  );

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      full_scale_range_out       <= 2'h0;
      cutoff_shift_out           <= 4'h0;
      filtered_output_select_out <= 1'b0;
      pulse_highpass_bypass_out  <= 1'b0;
      pulse_lowpass_enable_out   <= 1'b0;
    end
    else
    begin
      // The reserved range code is passed on as written; the core decides what it means.
      full_scale_range_out       <= range_cfg_ff[1:0];
      cutoff_shift_out           <= nxt_cutoff_shift;
      filtered_output_select_out <= range_cfg_ff[`AOF_BIT_FILT_OUT];
      pulse_highpass_bypass_out  <= cutoff_cfg_ff[`AOF_BIT_PULSE_BYP];
      pulse_lowpass_enable_out   <= cutoff_cfg_ff[`AOF_BIT_PULSE_LPF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample routing. The select is read from the stored bit, not the delayed copy,
  // so a sample taken the cycle after a write already follows the new setting.

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      out_sample_out   <= '0;
      pulse_sample_out <= '0;
      out_valid_out    <= 1'b0;
    end
    else
    begin
      out_valid_out <= sample_valid_in;
      if (sample_valid_in)
      begin
        out_sample_out   <= range_cfg_ff[`AOF_BIT_FILT_OUT] ? hp_sample_in : raw_sample_in;
        pulse_sample_out <= cutoff_cfg_ff[`AOF_BIT_PULSE_BYP] ? raw_sample_in : hp_sample_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  logic wr_range;
  logic wr_cut;
  assign wr_range = reg_wr_in && (reg_addr_in == `AOF_ADDR_RANGE_CFG);
  assign wr_cut   = reg_wr_in && (reg_addr_in == `AOF_ADDR_CUTOFF_CFG);

  a_id_readback: assert property (
    reg_rd_in && reg_addr_in == `AOF_ADDR_IDENTITY |=> reg_rvalid_out && reg_rdata_out == ID_VALUE)
    else $error("identity read returned a wrong value");

  a_filt_route: assert property (
    sample_valid_in && range_cfg_ff[`AOF_BIT_FILT_OUT] |=> out_valid_out && out_sample_out == $past(hp_sample_in))
    else $error("filtered sample not routed to output");

  a_raw_route: assert property (
    sample_valid_in && !range_cfg_ff[`AOF_BIT_FILT_OUT] |=> out_sample_out == $past(raw_sample_in))
    else $error("raw sample not routed to output");

  a_range_follow: assert property (
    wr_range |=> ##1 full_scale_range_out == $past(reg_wdata_in[1:0], 2))
    else $error("full scale range did not follow the write");

  a_cut_normal: assert property (
    osmode_in == AOF_OS_NORMAL && odr_in == 3'h2 |=> cutoff_shift_out == 4'h1 + {2'b00, $past(cutoff_cfg_ff[1:0])})
    else $error("normal mode cutoff wrong at 200 Hz");

  a_cut_lpln: assert property (
    osmode_in == AOF_OS_LPLN && odr_in >= 3'h5 |=> cutoff_shift_out == 4'h5 + {2'b00, $past(cutoff_cfg_ff[1:0])})
    else $error("low-noise low-power cutoff wrong at slow rate");

  a_cut_hires: assert property (
    osmode_in == AOF_OS_HIRES |=> cutoff_shift_out == {2'b00, $past(cutoff_cfg_ff[1:0])})
    else $error("high-resolution cutoff depends on rate");

  a_cut_lp: assert property (
    osmode_in == AOF_OS_LP && odr_in == 3'h4 |=> cutoff_shift_out == 4'h4 + {2'b00, $past(cutoff_cfg_ff[1:0])})
    else $error("low-power cutoff wrong at 50 Hz");

  // Mode and rate must hold through the cycle after the write, else the two counts are not comparable.
  a_cut_halving: assert property (
    wr_cut && reg_wdata_in[1:0] == 2'h3 && cutoff_cfg_ff[1:0] == 2'h0 ##1 $stable(osmode_in) && $stable(odr_in)
    |=> cutoff_shift_out == $past(cutoff_shift_out, 1) + 4'h3)
    else $error("cutoff did not halve per select step");

  a_pulse_byp: assert property (
    sample_valid_in && cutoff_cfg_ff[`AOF_BIT_PULSE_BYP] |=> pulse_sample_out == $past(raw_sample_in))
    else $error("pulse path not bypassing the high-pass filter");

  a_pulse_lpf: assert property (
    wr_cut |=> ##1 pulse_lowpass_enable_out == $past(reg_wdata_in[`AOF_BIT_PULSE_LPF], 2))
    else $error("pulse low-pass enable did not follow the write");

  a_unused_zero: assert property (
    reg_rd_in && reg_addr_in != `AOF_ADDR_IDENTITY |=> (reg_rdata_out & 8'hCC) == 8'h00)
    else $error("unused bit read back as one");

  // Spare bits are checked per register, since the two registers keep different bit sets.
  a_range_spare: assert property (
    reg_rd_in && reg_addr_in == `AOF_ADDR_RANGE_CFG |=> (reg_rdata_out & ~`AOF_RANGE_MASK) == 8'h00)
    else $error("spare bit of range register read back as one");

  a_cut_spare: assert property (
    reg_rd_in && reg_addr_in == `AOF_ADDR_CUTOFF_CFG |=> (reg_rdata_out & ~`AOF_CUTOFF_MASK) == 8'h00)
    else $error("spare bit of cutoff register read back as one");

  a_id_no_store: assert property (
    reg_wr_in && reg_addr_in == `AOF_ADDR_IDENTITY |=> $stable(range_cfg_ff) && $stable(cutoff_cfg_ff))
    else $error("identity write changed a configuration register");

  a_filt_follow: assert property (
    wr_range |=> ##1 filtered_output_select_out == $past(reg_wdata_in[`AOF_BIT_FILT_OUT], 2))
    else $error("filtered output select did not follow the write");

  a_byp_follow: assert property (
    wr_cut |=> ##1 pulse_highpass_bypass_out == $past(reg_wdata_in[`AOF_BIT_PULSE_BYP], 2))
    else $error("pulse bypass did not follow the write");

  c_filt_write: cover property (wr_range && reg_wdata_in[`AOF_BIT_FILT_OUT]);
  c_halving_step: cover property (wr_cut && reg_wdata_in[1:0] == 2'h3 && cutoff_cfg_ff[1:0] == 2'h0);
  c_cut_slow_lp: cover property (osmode_in == AOF_OS_LP && odr_in == 3'h7 && cutoff_cfg_ff[1:0] == 2'h3);
  c_id_read: cover property (reg_rd_in && reg_addr_in == `AOF_ADDR_IDENTITY);
  c_bypass_sample: cover property (sample_valid_in && cutoff_cfg_ff[`AOF_BIT_PULSE_BYP]);

endmodule

// ---- dv/aof_host_model.sv ----
// Host processor model driving the register port of the filter configuration block.
module aof_host_model
(
  // Clock
  input  wire logic       clock_in,
  // Register port
  output logic [7:0]      reg_addr_out,
  output logic            reg_wr_out,
  output logic [7:0]      reg_wdata_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       reg_rvalid_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One byte access; a missing read answer comes back unknown so that any check on it fails.
  // Idle address and data are inverted so stale values can never look like a live request.
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    @(negedge clock_in);
    reg_addr_out  = addr;
    reg_wdata_out = wdata;
    reg_wr_out    = wr;
    reg_rd_out    = !wr;
    @(negedge clock_in);
    // The answer stands for one cycle only, so it is taken before the strobe is dropped.
    rdata = reg_rvalid_in ? reg_rdata_in : 8'hxx;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_addr_out  = ~addr;
    reg_wdata_out = ~wdata;
    @(negedge clock_in);
  endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the acceleration output filter configuration block.
module tb
  import aof_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Arbitrary identity value for this bench.
  localparam logic [7:0] ID_VAL = 8'h3C;

  logic        clock_in     = 1'b0;
  logic        reset_n_in   = 1'b0;
  aof_odr_t    odr          = 3'h0;
  aof_osmode_e osmode       = AOF_OS_NORMAL;
  logic        sample_valid = 1'b0;
  aof_axes_s   raw_sample   = 36'h0;
  aof_axes_s   hp_sample    = 36'h0;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  rdata;
  logic        rvalid;
  aof_axes_s   out_sample;
  aof_axes_s   pulse_sample;
  logic        out_valid;
  logic [1:0]  range_code;
  logic [3:0]  shift;
  logic        filt;
  logic        byp;
  logic        lpf;
  int          bad_count    = 0;
  int          total_checks = 0;

  always #2.5 clock_in = ~clock_in;

  aof_host_model u_host (.clock_in(clock_in), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
    .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));

  aof_top #(.ID_VALUE(ID_VAL)) u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .odr_in(odr), .osmode_in(osmode),
    .sample_valid_in(sample_valid), .raw_sample_in(raw_sample), .hp_sample_in(hp_sample),
    .out_sample_out(out_sample), .out_valid_out(out_valid), .pulse_sample_out(pulse_sample),
    .full_scale_range_out(range_code), .cutoff_shift_out(shift), .filtered_output_select_out(filt),
    .pulse_highpass_bypass_out(byp), .pulse_lowpass_enable_out(lpf));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Halving count: fast rates share one ladder in normal and low-noise low-power mode only; slow rates sit on a per-mode floor.
  function automatic logic [3:0] exp_shift(input logic [1:0] m, input logic [2:0] o, input logic [1:0] s);
    logic [3:0] b;
    b = (o > 3'h1) ? 4'(o) - 4'h1 : 4'h0;
    if (m == 2'h2)
      b = 4'h0;
    else if (m == 2'h3)
      b = (o > 3'h4) ? 4'h6 : 4'(o);
    else if (o > 3'h4)
      b = (m == 2'h1) ? 4'h5 : 4'h3;
    return b + 4'(s);
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_case();
    logic [7:0] d;
    check("config outs", {range_code, filt, byp, lpf}, 36'h0);
    u_host.access(1'b0, 8'h0E, 8'h00, d);
    check("range reset", d, 36'h0);
    u_host.access(1'b0, 8'h0F, 8'h00, d);
    check("cutoff reset", d, 36'h0);
  endtask

  task automatic regs_case();
    logic [7:0] d;
    u_host.access(1'b1, 8'h0D, 8'hFF, d);
    u_host.access(1'b0, 8'h0D, 8'h00, d);
    check("identity", d, ID_VAL);
    u_host.access(1'b0, 8'h20, 8'h00, d);
    check("unmapped", d, 36'h0);
    for (int i = 0; i < 4; i++)
    begin
      u_host.access(1'b1, 8'h0E, 8'hFC | 8'(i), d);
      u_host.access(1'b0, 8'h0E, 8'h00, d);
      check("range reg", d, 8'h10 | 8'(i));
      check("range out", range_code, 36'(i));
      check("filter sel", filt, 36'h1);
    end
    u_host.access(1'b1, 8'h0F, 8'hDE, d);
    u_host.access(1'b0, 8'h0F, 8'h00, d);
    check("cutoff reg", d, 36'h12);
    check("bypass lowpass", {byp, lpf}, 36'h1);
  endtask

  task automatic cutoff_case();
    logic [7:0] d;
    for (int s = 0; s < 4; s++)
    begin
      u_host.access(1'b1, 8'h0F, 8'(s), d);
      for (int m = 0; m < 4; m++)
        for (int o = 0; o < 8; o++)
        begin
          @(negedge clock_in);
          osmode = aof_osmode_e'(m);
          odr    = 3'(o);
          @(negedge clock_in);
          check("cutoff", shift, exp_shift(2'(m), 3'(o), 2'(s)));
        end
    end
    // Step from select 0 straight to 3 at the slowest low-power corner: 0.25 Hz down to 0.031 Hz.
    u_host.access(1'b1, 8'h0F, 8'h00, d);
    u_host.access(1'b1, 8'h0F, 8'h03, d);
    check("cutoff step", shift, 36'h9);
  endtask

  task automatic sample_case();
    logic [7:0] d;
    aof_axes_s  r;
    aof_axes_s  h;
    for (int i = 0; i < 4; i++)
    begin
      u_host.access(1'b1, 8'h0E, 8'(i[0]) << 4, d);
      u_host.access(1'b1, 8'h0F, 8'(i[1]) << 5, d);
      r = 36'h1_2345_6789 + 36'(i);
      h = 36'hF_EDCB_A987 - 36'(i);
      @(negedge clock_in);
      sample_valid = 1'b1;
      raw_sample   = r;
      hp_sample    = h;
      @(negedge clock_in);
      sample_valid = 1'b0;
      raw_sample   = ~r;
      hp_sample    = ~h;
      check("out valid", out_valid, 36'h1);
      check("out data", out_sample, i[0] ? h : r);
      check("pulse data", pulse_sample, i[1] ? r : h);
      check("pulse cfg", {byp, lpf}, 36'(i[1]) << 1);
      @(negedge clock_in);
      check("out held", out_sample, i[0] ? h : r);
      check("out valid low", out_valid, 36'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge clock_in);
    reset_n_in = 1'b1;
    reset_case();
    regs_case();
    cutoff_case();
    sample_case();
    results();
  end

  // The whole run needs well under two thousand cycles; twenty thousand means a hang.
  initial
  begin
    #(20000 * 5);
    bad_count++;
    results();
  end
endmodule
